/* File: testbench/fsp_front_end_tb.sv */
// Self-checking bench for the serial flash front end.
module fsp_front_end_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import fsp_pkg::*;
  localparam int unsigned PCNT = 1000;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  fsp_pin_in_type pin_i;
  fsp_pin_out_type pin_o;
  logic standby_o;
  logic busy_o;
  logic [PAGE_AW-1:0] prog_page_o;
  logic [7:0] rx;
  logic [23:0] d;
  int num_errors = 0;
  int n_tests = 0;
  int busy_cnt = 0;

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (busy_o === 1'b1) busy_cnt++;

  fsp_front_end #(.PROG_CNT(PCNT)) u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .pin_i(pin_i),
    .pin_o(pin_o), .standby_o(standby_o), .busy_o(busy_o), .prog_page_o(prog_page_o));
  fsp_host_model u_host (.clk_i(clk_i), .dev_i(pin_o), .bus_o(pin_i));

  // ********
  // Helpers
  // ********
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wait_idle();
    for (int n = 0; busy_o !== 1'b0; n++)
    begin
      u_host.tick(1);
      if (n > 3000)
      begin
        num_errors++;
        stop_test();
      end
    end
  endtask

  task automatic cmd(input logic [7:0] op, input logic [15:0] adr, input logic m3);
    u_host.start(m3);
    u_host.shift(op, 1, rx);
    u_host.shift(adr[15:8], 1, rx);
    u_host.shift(adr[7:0], 1, rx);
  endtask

  task automatic op1(input logic [7:0] op, input logic [7:0] tx);
    u_host.start(1'b0);
    u_host.shift(op, 1, rx);
    u_host.shift(tx, 1, rx);
    u_host.stop();
  endtask

  task automatic wr3(input logic [15:0] adr, input logic [23:0] dat);
    cmd(CMD_BUF_WRITE, adr, 1'b0);
    for (int i = 2; i >= 0; i--) u_host.shift(dat[8*i +: 8], 1, rx);
    u_host.stop();
  endtask

  task automatic rd3(input logic [7:0] op, input logic [15:0] adr, input int w,
    input logic m3);
    cmd(op, adr, m3);
    for (int i = 2; i >= 0; i--)
    begin
      u_host.shift(8'h00, w, rx);
      d[8*i +: 8] = rx;
    end
    u_host.stop();
  endtask

  // ********
  // Scenarios
  // ********
  task automatic s_buffers();
    wr3(16'h020E, 24'hA5_3C5A);
    wr3(16'h8010, 24'h0F_F011);
    rd3(CMD_READ_SINGLE, 16'h020E, 1, 1'b1);
    chk(d, 24'hA5_3C5A);
    chk(pin_o.oe, 4'h0);
    rd3(CMD_READ_SINGLE, 16'h8010, 1, 1'b0);
    chk(d, 24'h0F_F011);
    u_host.start(1'b0);
    u_host.tick(8);
    chk(standby_o, 1'b0);
    u_host.stop();
    chk(standby_o, 1'b1);
    u_host.wiggle();
    chk(standby_o, 1'b1);
    chk(pin_o.oe, 4'h0);
  endtask

  task automatic s_page512();
    op1(CMD_CFG_WRITE, 8'h02);
    op1(CMD_STATUS_READ, 8'h00);
    chk(rx, 8'h82);
    wr3(16'h01FE, 24'h12_3456);
    rd3(CMD_READ_SINGLE, 16'h01FE, 1, 1'b0);
    chk(d, 24'h12_3456);
    op1(CMD_CFG_WRITE, 8'h00);
  endtask

  task automatic s_wide();
    cmd(CMD_READ_QUAD, 16'h8010, 1'b0);
    u_host.shift(8'h00, 4, rx);
    chk(pin_o.oe, 4'h0);
    u_host.stop();
    cmd(8'hEE, 16'h8010, 1'b0);
    u_host.shift(8'h00, 1, rx);
    chk(pin_o.oe, 4'h0);
    u_host.stop();
    op1(CMD_CFG_WRITE, 8'h01);
    rd3(CMD_READ_DUAL, 16'h8010, 2, 1'b0);
    chk(d, 24'h0F_F011);
    rd3(CMD_READ_QUAD, 16'h8010, 4, 1'b1);
    chk(d, 24'h0F_F011);
    op1(CMD_CFG_WRITE, 8'h00);
  endtask

  task automatic s_program();
    busy_cnt = 0;
    cmd(CMD_BUF_PROGRAM, 16'h0ABC, 1'b0);
    u_host.stop();
    chk(busy_o, 1'b1);
    chk(standby_o, 1'b0);
    wr3(16'h8020, 24'hC0_FFEE);
    cmd(CMD_BUF_PROGRAM, 16'h0123, 1'b0);
    u_host.stop();
    chk(prog_page_o, 12'hABC);
    wait_idle();
    chk(24'(busy_cnt), 24'(PCNT));
    u_host.tick(2);
    chk(standby_o, 1'b1);
    rd3(CMD_READ_SINGLE, 16'h8020, 1, 1'b0);
    chk(d, 24'hC0_FFEE);
  endtask

  task automatic s_reset_pin();
    cmd(CMD_BUF_PROGRAM, 16'h0055, 1'b0);
    u_host.stop();
    chk(busy_o, 1'b1);
    u_host.pull_reset(1'b1);
    u_host.tick(10);
    chk(busy_o, 1'b0);
    op1(CMD_CFG_WRITE, 8'h02);
    u_host.pull_reset(1'b0);
    u_host.tick(10);
    op1(CMD_STATUS_READ, 8'h00);
    chk(rx, 8'h80);
  endtask

  initial
  begin
    repeat (3) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    u_host.tick(8);
    chk(standby_o, 1'b1);
    chk(busy_o, 1'b0);
    chk(pin_o.oe, 4'h0);
    s_buffers();
    s_page512();
    s_wide();
    s_program();
    s_reset_pin();
    chk(24'(u_host.clash), 24'h00_0000);
    stop_test();
  end
endmodule // fsp_front_end_tb

/* File: testbench/fsp_host_model.sv */
// Behavioural host controller that frames and clocks the flash pins.
module fsp_host_model
  import fsp_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Pins
  input wire fsp_pkg::fsp_pin_out_type dev_i,
  output fsp_pkg::fsp_pin_in_type bus_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 4;
  logic cs_n = 1'b1;
  logic sck = 1'b0;
  logic idle_hi = 1'b0;
  logic noise = 1'b0;
  logic [3:0] hoe = 4'b0101;
  logic [3:0] hdat = 4'b1111;
  logic [3:0] io;
  int clash = 0;

  // ********
  // Pin levels
  // ********
  always @(posedge clk_i)
  begin
    noise <= ~noise;
    if ((dev_i.oe & hoe) != 4'h0) clash++;
  end

  // Released io0 and io1 float, io2 and io3 have pull-ups.
  always_comb
  begin
    for (int b = 0; b < 4; b++)
      if (dev_i.oe[b] === 1'b1) io[b] = dev_i.dat[b];
      else if (hoe[b]) io[b] = (b == 2) ? noise : hdat[b];
      else if (b > 1) io[b] = 1'b1;
      else io[b] = noise ^ b[0];
  end
  assign bus_o = {cs_n, sck, io};

  // ********
  // Host actions
  // ********
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Opens a frame with the clock idling low or high.
  task automatic start(input logic m3);
    idle_hi = m3;
    sck = m3;
    tick(2);
    cs_n = 1'b0;
    tick(HALF);
  endtask

  // Clocks 8/w cycles, drives tx on io0 only when w is 1, and takes w bits per edge late in the high phase.
  task automatic shift(input logic [7:0] tx, input int w, output logic [7:0] rx);
    rx = 8'h00;
    if (w > 1) hoe[0] = 1'b0;
    if (w > 2) hoe[2] = 1'b0;
    for (int i = 0; i < 8 / w; i++)
    begin
      sck = 1'b0;
      hdat[0] = tx[7 - i];
      tick(HALF);
      sck = 1'b1;
      tick(HALF);
      if (w == 1) rx = {rx[6:0], io[1]};
      else if (w == 2) rx = {rx[5:0], io[1:0]};
      else rx = {rx[3:0], io};
    end
  endtask

  // Closes the frame and keeps the gap between frames.
  task automatic stop();
    sck = idle_hi;
    tick(HALF);
    cs_n = 1'b1;
    tick(8);
    hoe[0] = 1'b1;
    hoe[2] = 1'b1;
    tick(8);
  endtask

  // Toggles the clock and serial input while the block is deselected.
  task automatic wiggle();
    for (int i = 0; i < 8; i++)
    begin
      sck = ~sck;
      hdat[0] = ~hdat[0];
      tick(HALF);
    end
  endtask

  task automatic pull_reset(input logic low);
    hoe[3] = low;
    hdat[3] = 1'b0;
  endtask
endmodule // fsp_host_model

/* File: verilog/fsp_buf_mem.sv */
// Two page buffers in one memory, with a registered read port.
module fsp_buf_mem #(
  parameter int unsigned AW = 11,
  parameter int unsigned DW = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  // Read port
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o <= '0;
    end
    else
    begin
      rdata_o <= mem_q[raddr_i];
    end
  end

endmodule // fsp_buf_mem

/* File: verilog/fsp_front_end.sv */
// Serial interface front end of a page-organised serial flash with two page buffers.
module fsp_front_end
  import fsp_pkg::*;
#(
  parameter int unsigned PROG_CNT = fsp_pkg::PROG_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Pins
  input wire fsp_pkg::fsp_pin_in_type pin_i,
  output fsp_pkg::fsp_pin_out_type pin_o,
  // Status
  output logic standby_o,
  output logic busy_o,
  output logic [fsp_pkg::PAGE_AW-1:0] prog_page_o
);

  import fsp_pkg::*;

  // ****************************************************************
  // Reset release and pin synchronisers
  // ****************************************************************
  typedef enum {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_CFG,
    ST_STATUS,
    ST_IGNORE
  } fsp_state_type;

  logic rst_a_q;
  logic rst_n_q;
  fsp_pin_in_type pin_f;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_a_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_a_q <= 1'b1;
      rst_n_q <= rst_a_q;
    end
  end

  fsp_sync #(
    .WIDTH($bits(fsp_pin_in_type)),
    .RST_VAL(6'b10_1111)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_q),
    .async_i(pin_i),
    .filt_o(pin_f)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  fsp_state_type state_q, state_d;
  fsp_width_type width_q, width_d;
  fsp_pin_out_type pin_q, pin_d;
  logic cs_prev_q, sck_prev_q;
  logic [7:0] cmd_q, cmd_d;
  logic [7:0] sh_q, sh_d;
  logic [2:0] bit_q, bit_d;
  logic byte_idx_q, byte_idx_d;
  logic [7:0] addr_hi_q, addr_hi_d;
  logic [BUF_AW-1:0] addr_q, addr_d;
  logic buf_q, buf_d;
  logic [7:0] out_q, out_d;
  logic [2:0] out_cnt_q, out_cnt_d;
  logic qe_q, qe_d;
  logic page512_q, page512_d;
  logic busy_q, busy_d;
  logic prog_buf_q, prog_buf_d;
  logic [31:0] prog_cnt_q, prog_cnt_d;
  logic [PAGE_AW-1:0] prog_page_q, prog_page_d;
  logic standby_q, standby_d;
  logic we_q, we_d;
  logic [BUF_AW:0] waddr_q, waddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic [7:0] rdata;

  logic sel, cs_fall, sck_rise, sck_fall, hard_rst, byte_done;
  logic [7:0] rx_byte, src;
  logic [BUF_AW-1:0] last_addr, addr_inc;

  fsp_buf_mem #(
    .AW(BUF_AW + 1),
    .DW(8)
  ) u_mem (
    .clk_i(clk_i),
    .rst_n_i(rst_n_q),
    .we_i(we_q),
    .waddr_i(waddr_q),
    .wdata_i(wdata_q),
    .raddr_i({buf_q, addr_q}),
    .rdata_o(rdata)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    sel = !pin_f.cs_n;
    cs_fall = cs_prev_q && !pin_f.cs_n;
    sck_rise = sel && pin_f.sck && !sck_prev_q;
    sck_fall = sel && !pin_f.sck && sck_prev_q;
    hard_rst = !qe_q && !pin_f.io[3];
    rx_byte = {sh_q[6:0], pin_f.io[0]};
    byte_done = sck_rise && (bit_q == 3'd7);
    last_addr = page512_q ? BUF_AW'(PAGE_LEN_SHORT - 1) : BUF_AW'(PAGE_LEN_LONG - 1);
    addr_inc = (addr_q == last_addr) ? '0 : addr_q + 1'b1;
    src = (cmd_q == CMD_STATUS_READ) ? {!busy_q, 5'd0, page512_q, qe_q} : rdata;
    state_d = state_q;
    width_d = width_q;
    pin_d = pin_q;
    cmd_d = cmd_q;
    sh_d = sh_q;
    bit_d = bit_q;
    byte_idx_d = byte_idx_q;
    addr_hi_d = addr_hi_q;
    addr_d = addr_q;
    buf_d = buf_q;
    out_d = out_q;
    out_cnt_d = out_cnt_q;
    qe_d = qe_q;
    page512_d = page512_q;
    busy_d = busy_q;
    prog_buf_d = prog_buf_q;
    prog_cnt_d = prog_cnt_q;
    prog_page_d = prog_page_q;
    we_d = 1'b0;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    if (busy_q)
    begin
      prog_cnt_d = prog_cnt_q - 1;
      if (prog_cnt_q == 32'd1)
      begin
        busy_d = 1'b0;
      end
    end
    if (sck_rise)
    begin
      sh_d = rx_byte;
      bit_d = bit_q + 3'd1;
    end
    if (hard_rst)
    begin
      state_d = ST_IDLE;
      busy_d = 1'b0;
      bit_d = '0;
      pin_d.oe = '0;
    end
    else if (!sel)
    begin
      state_d = ST_IDLE;
      pin_d.oe = '0;
      bit_d = '0;
    end
    else if (cs_fall)
    begin
      state_d = ST_CMD;
      bit_d = '0;
      byte_idx_d = 1'b0;
      out_cnt_d = '0;
    end
    else
    begin
      case (state_q)
        ST_CMD:
        begin
          if (byte_done)
          begin
            cmd_d = rx_byte;
            if (rx_byte == CMD_READ_SINGLE || rx_byte == CMD_BUF_WRITE
                || rx_byte == CMD_BUF_PROGRAM)
            begin
              state_d = ST_ADDR;
              width_d = FSP_WIDTH_X1;
            end
            else if (rx_byte == CMD_READ_DUAL)
            begin
              state_d = ST_ADDR;
              width_d = FSP_WIDTH_X2;
            end
            else if (rx_byte == CMD_READ_QUAD && qe_q)
            begin
              state_d = ST_ADDR;
              width_d = FSP_WIDTH_X4;
            end
            else if (rx_byte == CMD_CFG_WRITE)
            begin
              state_d = ST_CFG;
            end
            else if (rx_byte == CMD_STATUS_READ)
            begin
              state_d = ST_RDATA;
              width_d = FSP_WIDTH_X1;
            end
            else
            begin
              state_d = ST_IGNORE;
            end
          end
        end
        ST_ADDR:
        begin
          if (byte_done && !byte_idx_q)
          begin
            addr_hi_d = rx_byte;
            byte_idx_d = 1'b1;
          end
          else if (byte_done)
          begin
            buf_d = addr_hi_q[ADDR_BUF_SEL_BIT];
            addr_d = {addr_hi_q[BUF_AW-9:0], rx_byte};
            if (cmd_q == CMD_BUF_WRITE)
            begin
              state_d = ST_WDATA;
            end
            else if (cmd_q == CMD_BUF_PROGRAM)
            begin
              state_d = ST_IGNORE;
              if (!busy_q)
              begin
                busy_d = 1'b1;
                prog_cnt_d = PROG_CNT;
                prog_buf_d = addr_hi_q[ADDR_BUF_SEL_BIT];
                prog_page_d = {addr_hi_q[PAGE_AW-9:0], rx_byte};
              end
            end
            else
            begin
              state_d = ST_RDATA;
            end
          end
        end
        ST_WDATA:
        begin
          if (byte_done)
          begin
            we_d = !(busy_q && prog_buf_q == buf_q);
            waddr_d = {buf_q, addr_q};
            wdata_d = rx_byte;
            addr_d = addr_inc;
          end
        end
        ST_CFG:
        begin
          if (byte_done)
          begin
            qe_d = rx_byte[CFG_QE_BIT];
            page512_d = rx_byte[CFG_PAGE512_BIT];
            state_d = ST_IGNORE;
          end
        end
        ST_RDATA:
        begin
          if (sck_fall)
          begin
            out_d = (out_cnt_q == '0) ? src : out_q;
            if (out_cnt_q == '0 && cmd_q != CMD_STATUS_READ)
            begin
              addr_d = addr_inc;
            end
            case (width_q)
              FSP_WIDTH_X2:
              begin
                pin_d.oe = OE_DUAL;
                pin_d.dat = {2'b00, out_d[7:6]};
                out_d = {out_d[5:0], 2'b00};
                out_cnt_d = (out_cnt_q == '0) ? 3'd3 : out_cnt_q - 3'd1;
              end
              FSP_WIDTH_X4:
              begin
                pin_d.oe = OE_QUAD;
                pin_d.dat = out_d[7:4];
                out_d = {out_d[3:0], 4'h0};
                out_cnt_d = (out_cnt_q == '0) ? 3'd1 : out_cnt_q - 3'd1;
              end
              default:
              begin
                pin_d.oe = OE_SINGLE;
                pin_d.dat = {2'b00, out_d[7], 1'b0};
                out_d = {out_d[6:0], 1'b0};
                out_cnt_d = out_cnt_q - 3'd1;
              end
            endcase
          end
        end
        default:
        begin
          state_d = state_q;
        end
      endcase
    end
    standby_d = !sel && !busy_d;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= ST_IDLE;
      width_q <= FSP_WIDTH_X1;
      pin_q <= '0;
      cs_prev_q <= 1'b1;
      sck_prev_q <= 1'b0;
      cmd_q <= '0;
      sh_q <= '0;
      bit_q <= '0;
      byte_idx_q <= 1'b0;
      addr_hi_q <= '0;
      addr_q <= '0;
      buf_q <= 1'b0;
      out_q <= '0;
      out_cnt_q <= '0;
      qe_q <= CFG_QE_RESET;
      page512_q <= CFG_PAGE512_RESET;
      busy_q <= 1'b0;
      prog_buf_q <= 1'b0;
      prog_cnt_q <= '0;
      prog_page_q <= '0;
      standby_q <= 1'b1;
      we_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      width_q <= width_d;
      pin_q <= pin_d;
      cs_prev_q <= pin_f.cs_n;
      sck_prev_q <= pin_f.sck;
      cmd_q <= cmd_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      byte_idx_q <= byte_idx_d;
      addr_hi_q <= addr_hi_d;
      addr_q <= addr_d;
      buf_q <= buf_d;
      out_q <= out_d;
      out_cnt_q <= out_cnt_d;
      qe_q <= qe_d;
      page512_q <= page512_d;
      busy_q <= busy_d;
      prog_buf_q <= prog_buf_d;
      prog_cnt_q <= prog_cnt_d;
      prog_page_q <= prog_page_d;
      standby_q <= standby_d;
      we_q <= we_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
    end
  end

  assign pin_o = pin_q;
  assign standby_o = standby_q;
  assign busy_o = busy_q;
  assign prog_page_o = prog_page_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_q);

  sequence s_frame_open;
    cs_fall && !hard_rst;
  endsequence
  sequence s_in_cmd;
    state_q == ST_CMD && bit_q == 3'd0;
  endsequence

  property p_frame_start;
    s_frame_open |=> s_in_cmd;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame did not open");

  property p_deselect_hiz;
    !sel |=> pin_q.oe == 4'b0000;
  endproperty
  a_deselect_hiz: assert property (p_deselect_hiz) else $error("driver on while deselected");

  property p_no_accept;
    !sel |=> !we_q && bit_q == 3'd0;
  endproperty
  a_no_accept: assert property (p_no_accept) else $error("input taken while deselected");

  property p_standby_wait;
    busy_q |-> !standby_q;
  endproperty
  a_standby_wait: assert property (p_standby_wait) else $error("standby during program");

  property p_standby_after;
    !busy_q && !sel && !busy_d |=> standby_q;
  endproperty
  a_standby_after: assert property (p_standby_after) else $error("standby not entered");

  property p_rise_sample;
    sck_rise && !hard_rst |=> sh_q[0] == $past(pin_f.io[0]);
  endproperty
  a_rise_sample: assert property (p_rise_sample) else $error("input not sampled on rise");

  property p_launch_fall;
    $changed(pin_q.dat) |-> $past(sck_fall);
  endproperty
  a_launch_fall: assert property (p_launch_fall) else $error("output moved off falling edge");

  property p_dual_oe;
    sck_fall && state_q == ST_RDATA && width_q == FSP_WIDTH_X2 && !cs_fall && !hard_rst
      |=> pin_q.oe == OE_DUAL;
  endproperty
  a_dual_oe: assert property (p_dual_oe) else $error("dual read drivers wrong");

  property p_quad_gate;
    !qe_q |-> pin_q.oe[3:2] == 2'b00;
  endproperty
  a_quad_gate: assert property (p_quad_gate) else $error("upper lines driven without enable");

  property p_prog_runs;
    busy_q && prog_cnt_q > 32'd1 && !hard_rst |=> busy_q;
  endproperty
  a_prog_runs: assert property (p_prog_runs) else $error("program ended early");

  property p_reset_pin;
    hard_rst |=> state_q == ST_IDLE && !busy_q;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin did not abort");

endmodule // fsp_front_end

/* File: verilog/fsp_pkg.sv */
// Constants and carrier types shared by the serial flash front end.
package fsp_pkg;

  // ****************************************************************
  // Geometry and timing
  // ****************************************************************
  localparam int unsigned PAGE_LEN_LONG = 528;
  localparam int unsigned PAGE_LEN_SHORT = 512;
  localparam int unsigned PAGE_COUNT = 4096;
  localparam int unsigned PAGE_AW = 12;
  localparam int unsigned BUF_AW = 10;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned PROG_TIME_NS = 100000;
  localparam int unsigned PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Commands and fields
  // ****************************************************************
  localparam logic [7:0] CMD_READ_SINGLE = 8'h10;
  localparam logic [7:0] CMD_READ_DUAL = 8'h11;
  localparam logic [7:0] CMD_READ_QUAD = 8'h12;
  localparam logic [7:0] CMD_BUF_WRITE = 8'h20;
  localparam logic [7:0] CMD_BUF_PROGRAM = 8'h30;
  localparam logic [7:0] CMD_CFG_WRITE = 8'h40;
  localparam logic [7:0] CMD_STATUS_READ = 8'h50;
  localparam int unsigned ADDR_BUF_SEL_BIT = 7;
  localparam int unsigned CFG_QE_BIT = 0;
  localparam int unsigned CFG_PAGE512_BIT = 1;
  localparam int unsigned STAT_READY_BIT = 7;
  localparam logic CFG_QE_RESET = 1'b0;
  localparam logic CFG_PAGE512_RESET = 1'b0;
  localparam logic [3:0] OE_SINGLE = 4'b0010;
  localparam logic [3:0] OE_DUAL = 4'b0011;
  localparam logic [3:0] OE_QUAD = 4'b1111;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    FSP_WIDTH_X1,
    FSP_WIDTH_X2,
    FSP_WIDTH_X4
  } fsp_width_type;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic [3:0] io;
  } fsp_pin_in_type;

  typedef struct packed {
    logic [3:0] dat;
    logic [3:0] oe;
  } fsp_pin_out_type;

endpackage

/* File: verilog/fsp_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
module fsp_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] filt_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] filt_d;

  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_o[i];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      filt_o <= RST_VAL;
    end
    else
    begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_o <= filt_d;
    end
  end

endmodule // fsp_sync
